// ### hdl/usb_host_channel_status_flags.v
// Host channel event flags with interrupt mask, packet counter and AXI4-Lite slave
// Assumes link events arrive as one-cycle pulses from logic on clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "chan_flags_regs.vh"

// How it works
// RULE1 - CRC, timeout, stuffing, false EOP set bit7
// RULE2 - Error or software disable sets halted bit1
// RULE3 - Clean transfer end sets done bit0
// RULE4 - ACK sent or received sets bit5
// RULE5 - NAK received sets bit4
// RULE6 - STALL received sets bit3
// RULE7 - Wrong data PID toggle sets bit10
// RULE8 - Missed periodic frame sets bit9
// RULE9 - Overlong device transmission sets bit8
// RULE10 - Software keeps unused bits at reset
// RULE11 - Mask bit one lets flag interrupt
// RULE12 - Count packets down, zero means done
// RULE13 - Flags stay until written one; the code also clears every flag when the flag register is read
module usb_host_channel_status_flags #(
  parameter PKT_W = 10
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ev_crc_fail,
  input  wire        ev_timeout,
  input  wire        ev_bitstuff,
  input  wire        ev_false_eop,
  input  wire        ev_ack,
  input  wire        ev_nak,
  input  wire        ev_stall,
  input  wire        ev_toggle_bad,
  input  wire        ev_frame_miss,
  input  wire        ev_babble,
  input  wire        ev_packet_ok,
  output reg         channel_active,
  output wire        irq
);

  reg  [31:0]      flags;
  reg  [31:0]      mask;
  reg  [PKT_W-1:0] packets_remaining;
  reg              halt_req;
  reg              aw_held;
  reg              w_held;
  reg  [11:0]      aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  reg  [31:0]      next_flags;
  reg  [31:0]      set_bits;
  reg  [31:0]      clr_bits;
  reg  [31:0]      rd_word;
  reg  [1:0]       rd_resp;
  wire             fault;
  wire             do_write;
  wire             do_read;
  wire [3:0]       log_rd;
  wire [31:0]      pkt_word;

  // Apply byte strobes so a partial write touches only its lanes
  function [31:0] lanes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      lanes = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lanes[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  function [31:0] bit_at;
    input integer pos;
    begin
      bit_at = 32'h0000_0001 << pos;
    end
  endfunction

  // Write address and data may arrive in either order; hold each until both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `OFS_EVENT_FLAGS || aw_addr == `OFS_EVENT_MASK
            || aw_addr == `OFS_PACKETS || aw_addr == `OFS_CHAN_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign fault = ev_crc_fail | ev_timeout | ev_bitstuff | ev_false_eop;

  // Counter takes only its own low bits of the written word
  assign pkt_word = lanes({{(32-PKT_W){1'b0}}, packets_remaining}, w_data, w_strb);

  // Hardware sets win over a clear arriving in the same cycle
  always @* begin
    set_bits = 32'h0000_0000;
    if (fault) begin
      set_bits = set_bits | bit_at(`BIT_FAULT);             // [RULE1]
    end
    if (channel_active && (fault || halt_req || ev_babble || ev_frame_miss)) begin
      set_bits = set_bits | bit_at(`BIT_HALTED);            // [RULE2]
    end
    if (channel_active && ev_packet_ok && !fault
        && packets_remaining == {{(PKT_W-1){1'b0}}, 1'b1}) begin
      set_bits = set_bits | bit_at(`BIT_DONE);              // [RULE3] [RULE12]
    end
    if (ev_ack) begin
      set_bits = set_bits | bit_at(`BIT_ACK);               // [RULE4]
    end
    if (ev_nak) begin
      set_bits = set_bits | bit_at(`BIT_NAK);               // [RULE5]
    end
    if (ev_stall) begin
      set_bits = set_bits | bit_at(`BIT_STALL);             // [RULE6]
    end
    if (ev_toggle_bad) begin
      set_bits = set_bits | bit_at(`BIT_TOGGLE);            // [RULE7]
    end
    if (ev_frame_miss) begin
      set_bits = set_bits | bit_at(`BIT_OVERRUN);           // [RULE8]
    end
    if (ev_babble) begin
      set_bits = set_bits | bit_at(`BIT_BABBLE);            // [RULE9]
    end
    clr_bits = 32'h0000_0000;
    if (do_write && aw_addr == `OFS_EVENT_FLAGS) begin
      clr_bits = lanes(32'h0000_0000, w_data, w_strb);      // [RULE13]
    end
    // Reading the flags clears them too, so a poll loop needs no write-back
    if (do_read && s_axi_araddr == `OFS_EVENT_FLAGS) begin
      clr_bits = 32'hffff_ffff;
    end
    next_flags = ((flags & ~clr_bits) | set_bits) & `FLAGS_USED;  // [RULE10]
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      flags             <= `FLAGS_RESET;
      mask              <= `MASK_RESET;
      packets_remaining <= `PACKETS_RESET;
      channel_active    <= 1'b0;
      halt_req          <= 1'b0;
    end else begin
      flags    <= next_flags;
      halt_req <= 1'b0;
      if (do_write && aw_addr == `OFS_EVENT_MASK) begin
        mask <= lanes(mask, w_data, w_strb) & `FLAGS_USED;
      end
      if (do_write && aw_addr == `OFS_CHAN_CTRL && w_strb[0]) begin
        if (w_data[`CTRL_BIT_DISABLE]) begin
          halt_req <= 1'b1;
        end else if (w_data[`CTRL_BIT_ENABLE]) begin
          channel_active <= 1'b1;
        end
      end
      if (set_bits[`BIT_HALTED] || set_bits[`BIT_DONE]) begin
        channel_active <= 1'b0;
      end
      if (do_write && aw_addr == `OFS_PACKETS) begin
        packets_remaining <= pkt_word[PKT_W-1:0];
      end else if (channel_active && ev_packet_ok && !fault
                   && packets_remaining != {PKT_W{1'b0}}) begin
        packets_remaining <= packets_remaining - {{(PKT_W-1){1'b0}}, 1'b1};  // [RULE12]
      end
    end
  end

  assign irq = |(flags & mask);  // [RULE11]

  // Keeps the last handshake code seen; slot 0 only, a one-channel instance
  event_log_mem #(.WIDTH(4), .DEPTH(8), .AW(3)) u_log (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (ev_ack | ev_nak | ev_stall),
    .wr_addr (3'h0),
    .wr_data ({1'b1, ev_stall, ev_nak, ev_ack}),
    .rd_addr (3'h0),
    .rd_data (log_rd)
  );

  always @* begin
    rd_resp = `RESP_OKAY;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `OFS_EVENT_FLAGS) begin
      rd_word = flags;
    end else if (s_axi_araddr == `OFS_EVENT_MASK) begin
      rd_word = mask;
    end else if (s_axi_araddr == `OFS_PACKETS) begin
      rd_word = {{(32-PKT_W){1'b0}}, packets_remaining};
    end else if (s_axi_araddr == `OFS_CHAN_CTRL) begin
      rd_word = {31'h0000_0000, channel_active};
    end else if (s_axi_araddr == `OFS_LAST_PID) begin
      rd_word = {28'h000_0000, log_rd};
    end else begin
      rd_resp = `RESP_SLVERR;
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### hdl/chan_flags_regs.vh
// Register offsets, field positions and reset values for the channel flag block
// Assumes inclusion by bare name from the design files
`ifndef CHAN_FLAGS_REGS_VH
`define CHAN_FLAGS_REGS_VH

`define OFS_EVENT_FLAGS     12'h000
`define OFS_EVENT_MASK      12'h004
`define OFS_PACKETS         12'h008
`define OFS_CHAN_CTRL       12'h00c
`define OFS_LAST_PID        12'h010

`define BIT_DONE            0
`define BIT_HALTED          1
`define BIT_STALL           3
`define BIT_NAK             4
`define BIT_ACK             5
`define BIT_FAULT           7
`define BIT_BABBLE          8
`define BIT_OVERRUN         9
`define BIT_TOGGLE          10

`define FLAGS_USED          32'h0000_07bb
`define FLAGS_RESET         32'h0000_0000
`define MASK_RESET          32'h0000_0000
`define PACKETS_RESET       10'h000
`define CTRL_RESET          2'h0

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`define CTRL_BIT_ENABLE     0
`define CTRL_BIT_DISABLE    1

`endif

// ### hdl/event_log_mem.v
// Small log memory: the last handshake seen per slot, registered read data
// Assumes one clock, synchronous active-low reset, single write and read port
`timescale 1ns/10ps
`default_nettype none

module event_log_mem #(
  parameter WIDTH = 4,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             nrst,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
      rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ### testbench/usb_flags_monitor.sv
// Bus handshake and flag checks on the channel flag block
// Assumes a bind to the top module on one clock
`timescale 1ns/10ps
`default_nettype none
module usb_flags_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic channel_active,
  input wire logic ev_crc_fail,
  input wire logic ev_timeout
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  // Only a bus access may clear a flag, so irq holds otherwise
  chk_irq_sticky: assert property (irq && !s_axi_awvalid && !s_axi_arvalid &&
    !s_axi_wvalid && !$past(s_axi_wvalid) &&
    !$past(s_axi_awvalid) && !$past(s_axi_arvalid) |=> irq)
    else $error("irq dropped without access");
  chk_error_halt: assert property (channel_active && (ev_crc_fail || ev_timeout)
    |=> !channel_active)
    else $error("channel still active after error");
endmodule
bind usb_host_channel_status_flags usb_flags_monitor u_mon (.*);
`default_nettype wire

// ### testbench/usb_device_model.sv
// Attached device stand-in: one-cycle link event pulses
// Assumes the caller shares the block clock
`timescale 1ns/10ps
`default_nettype none
module usb_device_model (
  input wire logic        clk_sys,
  output var logic [10:0] ev
);
  initial ev = 11'h000;
  // Order: crc, timeout, stuff, eop, ack, nak, stall, toggle, frame, babble, packet
  task automatic send(input int code);
    @(posedge clk_sys);
    ev <= 11'h001 << code;
    @(posedge clk_sys);
    ev <= 11'h000;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_usb_host_channel_status_flags.sv
// Register-level test of the channel flag block
// Assumes the device model pulses events on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "chan_flags_regs.vh"
module test_usb_host_channel_status_flags;
  logic        clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, ah, wh, ad, wd;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         channel_active, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         ev_crc_fail, ev_timeout, ev_bitstuff, ev_false_eop, ev_ack, ev_nak;
  wire         ev_stall, ev_toggle_bad, ev_frame_miss, ev_babble, ev_packet_ok;
  wire  [10:0] ev;
  int          miscompares, n_checks;
  int          pos [10] = '{`BIT_FAULT, `BIT_FAULT, `BIT_FAULT, `BIT_FAULT, `BIT_ACK,
                            `BIT_NAK, `BIT_STALL, `BIT_TOGGLE, `BIT_OVERRUN, `BIT_BABBLE};
  assign {ev_packet_ok, ev_babble, ev_frame_miss, ev_toggle_bad, ev_stall, ev_nak, ev_ack,
          ev_false_eop, ev_bitstuff, ev_timeout, ev_crc_fail} = ev;
  usb_host_channel_status_flags u_dut (.*);
  usb_device_model u_dev (.clk_sys(clk_sys), .ev(ev));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      #1;
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      ad = ad | ah;
      wd = wd | wh;
    end
    do begin
      #1;
      ah = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
    end while (!ah);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      ah = s_axi_arready;
      @(posedge clk_sys);
    end while (!ah);
    s_axi_arvalid <= 1'b0;
    do begin
      #1;
      ah = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
    end while (!ah);
    s_axi_rready <= 1'b0;
  endtask
  // The test is about two hundred cycles, so this only cuts a real hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict;
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`OFS_EVENT_MASK);
    check("mask reset", d, `MASK_RESET);
    rd(12'h020);
    check("unmapped read", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(12'h020, 32'h0);
    check("unmapped write", {30'h0, r}, {30'h0, `RESP_SLVERR});
    for (int i = 0; i < 10; i++) begin
      u_dev.send(i);
      repeat (3) @(posedge clk_sys);
      #1;
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(`OFS_EVENT_FLAGS);
      check("event flag", d, 32'h1 << pos[i]);
      rd(`OFS_EVENT_FLAGS);
      check("flag cleared", d, 32'h0);
    end
    wr(`OFS_EVENT_MASK, `FLAGS_USED);
    rd(`OFS_EVENT_MASK);
    check("mask", d, `FLAGS_USED);
    u_dev.send(5);
    #1;
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(`OFS_EVENT_FLAGS, 32'h0);
    #1;
    check("irq after zero", {31'h0, irq}, 32'h1);
    wr(`OFS_EVENT_FLAGS, 32'h1 << `BIT_NAK);
    #1;
    check("irq after one", {31'h0, irq}, 32'h0);
    rd(`OFS_LAST_PID);
    check("last handshake", d, 32'ha);
    wr(`OFS_PACKETS, 32'h2);
    wr(`OFS_CHAN_CTRL, 32'h1);
    u_dev.send(10);
    rd(`OFS_PACKETS);
    check("count", d, 32'h1);
    rd(`OFS_EVENT_FLAGS);
    check("no early done", d, 32'h0);
    u_dev.send(10);
    #1;
    check("active after done", {31'h0, channel_active}, 32'h0);
    rd(`OFS_EVENT_FLAGS);
    check("done", d, 32'h1 << `BIT_DONE);
    rd(`OFS_PACKETS);
    check("count zero", d, 32'h0);
    wr(`OFS_CHAN_CTRL, 32'h1);
    u_dev.send(1);
    rd(`OFS_EVENT_FLAGS);
    check("error halt", d, (32'h1 << `BIT_FAULT) | (32'h1 << `BIT_HALTED));
    wr(`OFS_CHAN_CTRL, 32'h1);
    wr(`OFS_CHAN_CTRL, 32'h2);
    rd(`OFS_EVENT_FLAGS);
    check("disable halt", d, 32'h1 << `BIT_HALTED);
    give_verdict;
  end
endmodule
`default_nettype wire
